// >>> src/fhps_defs.vh
/*
 frequency hop phase sequencer: offsets, field positions, reset values and timing counts.
 assumes inclusion by every design file of the block; definitions only.
*/
`ifndef FHPS_DEFS_VH
`define FHPS_DEFS_VH

// register byte offsets on apb
`define FHPS_REG_CTRL 12'h000
`define FHPS_REG_STATUS 12'h004
`define FHPS_REG_CARRIER 12'h008
`define FHPS_REG_ADDR 12'h00c
`define FHPS_REG_DUR 12'h010
`define FHPS_REG_OFS 12'h014
`define FHPS_REG_COUNT 12'h018
`define FHPS_REG_FREQ 12'h01c
`define FHPS_REG_PHASE 12'h020

// ctrl fields
`define FHPS_CTRL_START 0
`define FHPS_CTRL_STOP 1
`define FHPS_CTRL_SYNC 2
`define FHPS_CTRL_PMODE_LO 4
`define FHPS_CTRL_PMODE_HI 5

// phase modes
`define FHPS_PM_CONT 2'b00
`define FHPS_PM_MEM 2'b01
`define FHPS_PM_ABS 2'b10

// list geometry and sizes
`define FHPS_ENTRY_AW 6
`define FHPS_ENTRIES 64
`define FHPS_MEM_FREQS 16
`define FHPS_DUR_W 32
`define FHPS_FREQ_W 32

// system clock for unitless durations, and the least duration
`define FHPS_SYS_CLK_MHZ 200
`define FHPS_MIN_DUR_CLKS 32'h0000_000a
// cycles the list walker spends fetching an entry before it applies
`define FHPS_FETCH_CLKS 32'h0000_0002

`define FHPS_CTRL_RESET 32'h0000_0000
`define FHPS_CARRIER_RESET 32'h0000_0000

`endif

// >>> src/fhps_entry_mem.v
/*
 entry memory of the hopping list: duration and offset words, one write port, registered read.
 assumes a single clock; writes come from the apb slave in the top.
*/
`timescale 1ns/1ns
`include "fhps_defs.vh"
module fhps_entry_mem (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // write port
  input wire wr_en,
  input wire wr_sel_ofs,
  input wire [`FHPS_ENTRY_AW-1:0] wr_addr,
  input wire [31:0] wr_data,
  // read port
  input wire [`FHPS_ENTRY_AW-1:0] rd_addr,
  output reg [`FHPS_DUR_W-1:0] rd_dur,
  output reg [`FHPS_FREQ_W-1:0] rd_ofs
);
  reg [`FHPS_DUR_W-1:0] dur_mem [0:`FHPS_ENTRIES-1];
  reg [`FHPS_FREQ_W-1:0] ofs_mem [0:`FHPS_ENTRIES-1];

  always @(posedge core_clk) begin
    if (wr_en && !wr_sel_ofs) begin
      dur_mem[wr_addr] <= wr_data;
    end
    if (wr_en && wr_sel_ofs) begin
      ofs_mem[wr_addr] <= wr_data;
    end
  end

  // read data from a register so the sequencer sees stable words
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_dur <= 32'h0000_0000;
      rd_ofs <= 32'h0000_0000;
    end else begin
      rd_dur <= dur_mem[rd_addr];
      rd_ofs <= ofs_mem[rd_addr];
    end
  end
endmodule // fhps_entry_mem

// >>> src/fhps_phase_track.v
/*
 phase tracker for memory mode: sixteen slots, each holding a frequency and the
 phase that frequency would have reached running since time zero.
 assumes clear is pulsed at list start; phase accumulators are 32-bit turns.
*/
`timescale 1ns/1ns
`include "fhps_defs.vh"
module fhps_phase_track (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // control
  input wire clear,
  input wire load,
  input wire [`FHPS_FREQ_W-1:0] load_freq,
  // result
  output reg [31:0] mem_phase_ff,
  output reg hit_ff,
  output reg full_ff
);
  reg [31:0] slot_freq_ff [0:`FHPS_MEM_FREQS-1];
  reg [31:0] slot_phase_ff [0:`FHPS_MEM_FREQS-1];
  reg [`FHPS_MEM_FREQS-1:0] slot_used_ff;
  reg [4:0] hit_idx;
  reg [4:0] free_idx;
  reg [31:0] elapsed_ff;
  wire [63:0] first_phase;
  integer i;
  integer j;

  // phase a new frequency would have reached had it been on since time zero
  assign first_phase = {32'h0000_0000, load_freq} * {32'h0000_0000, elapsed_ff + 32'h0000_0001};

  always @* begin
    hit_idx = 5'h10;
    free_idx = 5'h10;
    for (i = `FHPS_MEM_FREQS - 1; i >= 0; i = i - 1) begin
      if (slot_used_ff[i] && slot_freq_ff[i] == load_freq) begin
        hit_idx = i[4:0];
      end
      if (!slot_used_ff[i]) begin
        free_idx = i[4:0];
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_used_ff <= 16'h0000;
      mem_phase_ff <= 32'h0000_0000;
      hit_ff <= 1'b0;
      full_ff <= 1'b0;
      elapsed_ff <= 32'h0000_0000;
      for (j = 0; j < `FHPS_MEM_FREQS; j = j + 1) begin
        slot_freq_ff[j] <= 32'h0000_0000;
        slot_phase_ff[j] <= 32'h0000_0000;
      end
    end else if (clear) begin
      slot_used_ff <= 16'h0000;
      mem_phase_ff <= 32'h0000_0000;
      hit_ff <= 1'b0;
      full_ff <= 1'b0;
      elapsed_ff <= 32'h0000_0000;
      for (j = 0; j < `FHPS_MEM_FREQS; j = j + 1) begin
        slot_phase_ff[j] <= 32'h0000_0000;
      end
    end else begin
      elapsed_ff <= elapsed_ff + 32'h0000_0001;
      // every slot keeps running as if its frequency were always on
      for (j = 0; j < `FHPS_MEM_FREQS; j = j + 1) begin
        slot_phase_ff[j] <= slot_phase_ff[j] + slot_freq_ff[j];
      end
      if (load) begin
        hit_ff <= !hit_idx[4];
        if (!hit_idx[4]) begin
          mem_phase_ff <= slot_phase_ff[hit_idx[3:0]] + slot_freq_ff[hit_idx[3:0]];
        end else if (!free_idx[4]) begin
          // a new frequency counts as running since zero: phase is f times elapsed cycles
          slot_used_ff[free_idx[3:0]] <= 1'b1;
          slot_freq_ff[free_idx[3:0]] <= load_freq;
          slot_phase_ff[free_idx[3:0]] <= first_phase[31:0];
          mem_phase_ff <= first_phase[31:0];
        end else begin
          // limitation: beyond sixteen frequencies the start phase falls back to zero
          full_ff <= 1'b1;
          mem_phase_ff <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // fhps_phase_track

// >>> src/fhps_sequencer.v
/*
 frequency hop phase sequencer top: apb register slave, hopping list walker and
 start-phase selection for the signal generation path.
 assumes seq_start and seg_start come from logic on core_clk (no synchroniser needed)
 and that core_clk is the 200 MHz system clock in which unitless durations count.
*/
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "fhps_defs.vh"
// Operation
// - list starts with sequence, time zero
// - hopping independent of sequence elements
// - one list, one transmitter
// - apply offset for duration, then next
// - offset relative to carrier frequency
// - start phase set by phase mode
// - continuous: keep last sample phase
// - memory: phase as if running continuously
// - memory mode tracks sixteen frequencies
// - absolute: start phase zero on change
// - sync: advance on segment start only
// - no sync: advance by elapsed duration
// - unitless durations count 200 MHz clocks
// - durations independent of off times
module fhps_sequencer (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // waveform segment sequencer side
  input wire seq_start,
  input wire seg_start,
  // signal generation side
  output reg [31:0] freq_out_ff,
  output reg [31:0] start_phase_ff,
  output reg phase_load_ff,
  output reg hop_active_ff
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_FETCH = 4'b0010;
  localparam ST_RUN = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [31:0] ctrl_ff;
  reg [31:0] carrier_ff;
  reg [`FHPS_ENTRY_AW-1:0] waddr_ff;
  reg [`FHPS_ENTRY_AW:0] count_ff;
  reg [`FHPS_ENTRY_AW-1:0] idx_ff;
  reg [31:0] dur_cnt_ff;
  reg [31:0] run_phase_ff;
  reg fetch_wait_ff;
  reg pend_ff;
  wire [31:0] rd_dur;
  wire [31:0] rd_ofs;
  wire [31:0] mem_phase;
  wire mem_hit;
  wire mem_full;
  wire wr_acc;
  wire rd_acc;
  wire mapped;
  wire start_req;
  wire mem_wr;
  wire sync_en;
  wire [1:0] pmode;
  wire last_entry;
  wire advance;
  wire [31:0] new_freq;
  wire list_go;
  wire stop_req;
  wire load_now;
  wire dur_done;
  wire [31:0] status_word;

  function [31:0] fhps_abs_freq;
    input [31:0] carrier;
    input [31:0] ofs;
    begin
      fhps_abs_freq = carrier + ofs;
    end
  endfunction

  function fhps_is_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      fhps_is_reg = (a == off);
    end
  endfunction

  // fetch latency is taken out of the count so a hop lasts exactly its duration
  function [31:0] fhps_run_dur;
    input [31:0] dur;
    begin
      fhps_run_dur = dur - `FHPS_FETCH_CLKS;
    end
  endfunction

  function [31:0] fhps_pick_phase;
    input [1:0] mode;
    input [31:0] run_phase;
    input [31:0] cur_phase;
    begin
      case (mode)
        `FHPS_PM_ABS: fhps_pick_phase = 32'h0000_0000;
        `FHPS_PM_CONT: fhps_pick_phase = run_phase;
        default: fhps_pick_phase = cur_phase;
      endcase
    end
  endfunction

  // zero-wait apb slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign mapped = paddr <= `FHPS_REG_PHASE && paddr[1:0] == 2'b00;
  assign pslverr = psel && penable && !mapped;
  assign start_req = wr_acc && fhps_is_reg(paddr, `FHPS_REG_CTRL) && pwdata[`FHPS_CTRL_START];
  assign mem_wr = wr_acc && (fhps_is_reg(paddr, `FHPS_REG_DUR) || fhps_is_reg(paddr, `FHPS_REG_OFS));
  assign sync_en = ctrl_ff[`FHPS_CTRL_SYNC];
  assign pmode = ctrl_ff[`FHPS_CTRL_PMODE_HI:`FHPS_CTRL_PMODE_LO];
  assign last_entry = ({1'b0, idx_ff} + 7'h01) >= count_ff;
  assign list_go = seq_start || start_req;
  assign stop_req = wr_acc && fhps_is_reg(paddr, `FHPS_REG_CTRL) && pwdata[`FHPS_CTRL_STOP];
  assign load_now = state_ff == ST_FETCH && !fetch_wait_ff;
  assign dur_done = dur_cnt_ff <= 32'h0000_0001;
  assign status_word = {22'h00_0000, idx_ff, mem_full, mem_hit, hop_active_ff, state_ff == ST_HOLD};
  assign advance = state_ff == ST_RUN && (sync_en ? (seg_start || pend_ff) : dur_done);
  assign new_freq = fhps_abs_freq(carrier_ff, rd_ofs);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `FHPS_CTRL_RESET;
      carrier_ff <= `FHPS_CARRIER_RESET;
      waddr_ff <= 6'h00;
      count_ff <= 7'h00;
    end else if (wr_acc) begin
      if (fhps_is_reg(paddr, `FHPS_REG_CTRL)) begin
        // start and stop are self-clearing strobes
        ctrl_ff <= pwdata & 32'h0000_0034;
      end
      // limitation: a new carrier shows at the next hop only
      if (fhps_is_reg(paddr, `FHPS_REG_CARRIER)) begin
        carrier_ff <= pwdata;
      end
      if (fhps_is_reg(paddr, `FHPS_REG_ADDR)) begin
        waddr_ff <= pwdata[5:0];
      end
      if (fhps_is_reg(paddr, `FHPS_REG_COUNT)) begin
        count_ff <= pwdata[6:0];
      end
      if (fhps_is_reg(paddr, `FHPS_REG_OFS)) begin
        waddr_ff <= waddr_ff + 6'h01;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        `FHPS_REG_CTRL: prdata <= ctrl_ff;
        `FHPS_REG_STATUS: prdata <= status_word;
        `FHPS_REG_CARRIER: prdata <= carrier_ff;
        `FHPS_REG_ADDR: prdata <= {26'h000_0000, waddr_ff};
        `FHPS_REG_COUNT: prdata <= {25'h000_0000, count_ff};
        `FHPS_REG_FREQ: prdata <= freq_out_ff;
        `FHPS_REG_PHASE: prdata <= start_phase_ff;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  fhps_entry_mem u_mem (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(mem_wr),
    .wr_sel_ofs(fhps_is_reg(paddr, `FHPS_REG_OFS)),
    .wr_addr(waddr_ff),
    .wr_data(pwdata),
    .rd_addr(idx_ff),
    .rd_dur(rd_dur),
    .rd_ofs(rd_ofs)
  );

  // sixteen tracked frequencies
  // cleared on every list start so tracked phases share time zero
  fhps_phase_track u_track (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clear(list_go),
    .load(load_now),
    .load_freq(new_freq),
    .mem_phase_ff(mem_phase),
    .hit_ff(mem_hit),
    .full_ff(mem_full)
  );

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (list_go && count_ff != 7'h00) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!fetch_wait_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (advance) begin
          nxt_state = last_entry ? ST_HOLD : ST_FETCH;
        end
      end
      ST_HOLD: begin
        if (list_go) begin
          nxt_state = ST_FETCH;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (stop_req) begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      idx_ff <= 6'h00;
      dur_cnt_ff <= 32'h0000_0000;
      fetch_wait_ff <= 1'b1;
      pend_ff <= 1'b0;
      freq_out_ff <= 32'h0000_0000;
      start_phase_ff <= 32'h0000_0000;
      phase_load_ff <= 1'b0;
      hop_active_ff <= 1'b0;
      run_phase_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      phase_load_ff <= 1'b0;
      hop_active_ff <= nxt_state == ST_FETCH || nxt_state == ST_RUN;
      // phase of last sample kept running
      run_phase_ff <= run_phase_ff + freq_out_ff;
      // segment starts during the fetch are remembered so none is lost
      if (state_ff == ST_FETCH && seg_start) begin
        pend_ff <= 1'b1;
      end else if (state_ff == ST_RUN) begin
        pend_ff <= 1'b0;
      end
      if (state_ff == ST_FETCH) begin
        fetch_wait_ff <= 1'b0;
      end else begin
        fetch_wait_ff <= 1'b1;
      end
      if ((state_ff == ST_IDLE || state_ff == ST_HOLD) && nxt_state == ST_FETCH) begin
        idx_ff <= 6'h00;
        run_phase_ff <= 32'h0000_0000;
      end else if (state_ff == ST_RUN && nxt_state == ST_FETCH) begin
        idx_ff <= idx_ff + 6'h01;
      end
      if (load_now) begin
        // supplier keeps it ten clocks or more
        dur_cnt_ff <= fhps_run_dur(rd_dur);
        freq_out_ff <= new_freq;
        phase_load_ff <= 1'b1;
        start_phase_ff <= fhps_pick_phase(pmode, run_phase_ff, start_phase_ff);
      end else if (state_ff == ST_RUN) begin
        dur_cnt_ff <= dur_cnt_ff - 32'h0000_0001;
      end
      if (phase_load_ff && pmode == `FHPS_PM_MEM) begin
        start_phase_ff <= mem_phase;
      end
    end
  end
endmodule // fhps_sequencer

// >>> test/fhps_seg_model.sv
/*
 segment sequencer model: one-cycle list-start and segment-start pulses.
 assumes the bench calls its tasks; both pulses are on core_clk.
*/
`timescale 1ns/1ns
module fhps_seg_model (
  // clock
  input wire core_clk,
  // pulses to the block
  output logic seq_start,
  output logic seg_start
);
  initial begin
    seq_start = 1'b0;
    seg_start = 1'b0;
  end
  task automatic pulse_seq();
    @(posedge core_clk) seq_start <= 1'b1;
    @(posedge core_clk) seq_start <= 1'b0;
  endtask
  task automatic pulse_seg();
    @(posedge core_clk) seg_start <= 1'b1;
    @(posedge core_clk) seg_start <= 1'b0;
  endtask
endmodule // fhps_seg_model

// >>> test/fhps_sequencer_properties.sv
/*
 port checker of the hop sequencer, bound to fhps_sequencer.
 assumes ctrl is only written while idle; mode and sync are tracked from apb writes.
*/
`timescale 1ns/1ns
`include "fhps_defs.vh"
module fhps_checker (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // segment side
  input wire seq_start,
  input wire seg_start,
  // generation side
  input wire [31:0] freq_out_ff,
  input wire [31:0] start_phase_ff,
  input wire phase_load_ff,
  input wire hop_active_ff
);
  reg sync_ff;
  reg [1:0] mode_ff;
  reg [3:0] since_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // saturating age of the last start pulse
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_ff <= 1'b0;
      mode_ff <= 2'b00;
      since_ff <= 4'hf;
    end else begin
      if (psel && penable && pwrite && paddr == `FHPS_REG_CTRL) begin
        sync_ff <= pwdata[`FHPS_CTRL_SYNC];
        mode_ff <= pwdata[`FHPS_CTRL_PMODE_HI:`FHPS_CTRL_PMODE_LO];
      end
      if (seg_start || seq_start) begin
        since_ff <= 4'h0;
      end else if (since_ff != 4'hf) begin
        since_ff <= since_ff + 4'h1;
      end
    end
  end
  property p_start_load;
    seq_start && !hop_active_ff |-> ##[2:3] phase_load_ff;
  endproperty
  a_start_load: assert property (p_start_load) else $error("no load after list start");
  property p_load_pulse;
    phase_load_ff |=> !phase_load_ff;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
  property p_freq_on_load;
    $changed(freq_out_ff) |-> phase_load_ff;
  endproperty
  a_freq_on_load: assert property (p_freq_on_load) else $error("frequency moved without load");
  property p_abs_zero;
    phase_load_ff && mode_ff == `FHPS_PM_ABS |-> start_phase_ff == 32'h0000_0000;
  endproperty
  a_abs_zero: assert property (p_abs_zero) else $error("absolute start phase not zero");
  property p_sync_cause;
    phase_load_ff && sync_ff |-> since_ff <= 4'h8;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync hop without segment start");
  property p_nonsync_gap;
    phase_load_ff && !sync_ff |=> !phase_load_ff [*8];
  endproperty
  a_nonsync_gap: assert property (p_nonsync_gap) else $error("hop sooner than least duration");
  property p_load_active;
    phase_load_ff |-> $past(hop_active_ff);
  endproperty
  a_load_active: assert property (p_load_active) else $error("load while list inactive");
  property p_slverr;
    psel && penable && paddr > `FHPS_REG_PHASE |-> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  cover property (phase_load_ff && sync_ff);
  cover property (phase_load_ff && mode_ff == `FHPS_PM_MEM);
  cover property (psel && penable && pslverr);
endmodule // fhps_checker
bind fhps_sequencer fhps_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .seq_start(seq_start),
  .seg_start(seg_start), .freq_out_ff(freq_out_ff), .start_phase_ff(start_phase_ff),
  .phase_load_ff(phase_load_ff), .hop_active_ff(hop_active_ff));

// >>> test/fhps_sequencer_test.sv
/*
 self-checking bench of the hop sequencer: apb register rows, then list runs per mode.
 assumes the segment model drives the start pulses and the checker is bound.
*/
`timescale 1ns/1ns
`include "fhps_defs.vh"
module fhps_sequencer_test;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} fhps_row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic er;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire seq_start;
  wire seg_start;
  wire [31:0] freq_out_ff;
  wire [31:0] start_phase_ff;
  wire phase_load_ff;
  wire hop_active_ff;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int st_cyc = 0;
  int ld_cyc[$];
  logic [31:0] ld_frq[$];
  logic [31:0] ld_ph[$];
  logic [31:0] car = 32'h1000_0000;
  logic [31:0] durs [3] = '{32'h0000_000a, 32'h0000_0014, 32'h0000_000a};
  logic [31:0] ofs [3] = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0300};
  fhps_row_t rows [5] = '{'{12'h008, 32'h1000_0000, 32'h1000_0000, 1'b0},
    '{12'h00c, 32'h0000_0005, 32'h0000_0005, 1'b0}, '{12'h00c, 32'h0000_00ff, 32'h0000_003f, 1'b0},
    '{12'h018, 32'h0000_0040, 32'h0000_0040, 1'b0}, '{12'h0fc, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
  always #4 core_clk = ~core_clk;
  fhps_sequencer u_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .seq_start(seq_start),
    .seg_start(seg_start), .freq_out_ff(freq_out_ff), .start_phase_ff(start_phase_ff),
    .phase_load_ff(phase_load_ff), .hop_active_ff(hop_active_ff));
  fhps_seg_model u_seg (.core_clk(core_clk), .seq_start(seq_start), .seg_start(seg_start));
  task automatic end_sim();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // run ceiling well above the expected few hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (seq_start === 1'b1) begin
      st_cyc <= cyc;
    end
    if (phase_load_ff === 1'b1) begin
      ld_cyc.push_back(cyc);
      ld_frq.push_back(freq_out_ff);
      ld_ph.push_back(start_phase_ff);
    end
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_loads(input int k);
    int n;
    n = 0;
    while (ld_cyc.size() < k && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(ld_cyc.size()), 32'(k));
  endtask
  task automatic run_list(input logic [31:0] ctrl);
    ld_cyc.delete();
    ld_frq.delete();
    ld_ph.delete();
    apb(1'b1, `FHPS_REG_CTRL, ctrl);
    u_seg.pulse_seq();
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    chk(freq_out_ff, 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd, rows[i].e);
      chk({31'h0, er}, {31'h0, rows[i].er});
    end
    apb(1'b1, `FHPS_REG_ADDR, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `FHPS_REG_DUR, durs[i]);
      apb(1'b1, `FHPS_REG_OFS, ofs[i]);
    end
    apb(1'b1, `FHPS_REG_COUNT, 32'h0000_0003);
    // absolute phase, timed hops
    run_list(32'h0000_0020);
    wait_loads(3);
    for (int i = 0; i < 3; i++) begin
      chk(ld_frq[i], car + ofs[i]);
      chk(ld_ph[i], 32'h0000_0000);
    end
    chk(32'((ld_cyc[2] - ld_cyc[1]) - (ld_cyc[1] - ld_cyc[0])), 32'h0000_000a);
    chk(32'(ld_cyc[1] - ld_cyc[0]), durs[0]);
    repeat (100) @(posedge core_clk);
    chk(freq_out_ff, car + ofs[2]);
    chk(32'(ld_cyc.size()), 32'h0000_0003);
    apb(1'b0, `FHPS_REG_FREQ, 32'h0000_0000);
    chk(rd, car + ofs[2]);
    // continuous phase, hops follow segment starts only
    run_list(32'h0000_0004);
    wait_loads(1);
    repeat (40) @(posedge core_clk);
    chk(32'(ld_cyc.size()), 32'h0000_0001);
    chk(freq_out_ff, car + ofs[0]);
    u_seg.pulse_seg();
    wait_loads(2);
    chk(ld_frq[1], car + ofs[1]);
    // stop mid-list, then memory phase with first-use slots
    apb(1'b1, `FHPS_REG_CTRL, 32'h0000_0002);
    run_list(32'h0000_0010);
    wait_loads(3);
    repeat (20) @(posedge core_clk);
    chk(start_phase_ff, (car + ofs[2]) * 32'(ld_cyc[2] - 1 - st_cyc));
    // reset in mid-run clears the outputs
    ld_cyc.delete();
    ld_frq.delete();
    ld_ph.delete();
    apb(1'b1, `FHPS_REG_CTRL, 32'h0000_0021);
    wait_loads(1);
    chk(ld_frq[0], car + ofs[0]);
    chk({31'h0, hop_active_ff}, 32'h0000_0001);
    rst_b <= 1'b0;
    @(posedge core_clk);
    chk(freq_out_ff, 32'h0000_0000);
    chk({31'h0, hop_active_ff}, 32'h0000_0000);
    rst_b <= 1'b1;
    end_sim();
  end
endmodule // fhps_sequencer_test
